// file: hdl/sps_defines.vh
// Behaviour
// - software write of 0 after reading 1 clears the transmit-empty flag
// - DMA write of the transmit holding register clears the transmit-empty flag
// - transmit-empty flag sets on shift load, transmit disable, reset; resets to 1
// - receive-full clears on DMA read, 0-after-1 write, receive disable, reset
// - receive-full sets when normal reception copies shift register to holding register
// - four request sources: overrun, underrun, receive full, transmit empty
// - receive-full and transmit-empty requests gated by their interrupt enable bits
// - overrun and underrun requests have no enable gating
// - receive-full request asserted when its flag is 1 and enabled
// - transmit-empty request asserted when its flag is 1 and enabled
// - overrun and underrun requests follow their error flags
// - only receive-full and transmit-empty requests may start DMA transfers
// - fixed priority: overrun, underrun, receive full, transmit empty
// - underrun flag sets when transmission starts while transmit-empty is 1
// - overrun flag sets when reception completes while receive-full is 1
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH
`define SPS_ADDR_CTRL 4'h0
`define SPS_ADDR_STAT 4'h4
`define SPS_ADDR_IRQ_STAT 4'h8
`define SPS_ADDR_IRQ_MASK 4'hC
`define SPS_CTRL_RX_EN 0
`define SPS_CTRL_TX_EN 1
`define SPS_CTRL_RX_IE 2
`define SPS_CTRL_TX_IE 3
`define SPS_CTRL_WMASK 16'h007F
`define SPS_STAT_RX_FULL 0
`define SPS_STAT_TX_EMPTY 1
`define SPS_STAT_OVERRUN 2
`define SPS_STAT_UNDERRUN 3
`define SPS_CTRL_RESET 16'h0000
`define SPS_STAT_RESET 16'h0002
`define SPS_RESP_OKAY 2'b00
`define SPS_RESP_SLVERR 2'b10
`endif

// file: hdl/sps_status_irq.v
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.vh"
module sps_status_irq
(
   // clock and reset
   input wire ref_clk_in,
   input wire rstn_in,
   // axi4-lite write address
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   input wire [3:0] s_axi_awaddr_in,
   // axi4-lite write data
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   // axi4-lite write response
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   output reg [1:0] s_axi_bresp_out,
   // axi4-lite read address
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   input wire [3:0] s_axi_araddr_in,
   // axi4-lite read data
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   // serial engine and DMA strobes, same clock
   input wire tx_load_shift_in,
   input wire tx_start_in,
   input wire rx_done_in,
   input wire dma_tx_write_in,
   input wire dma_rx_read_in,
   // control bits toward the serial engine
   output reg [6:0] serial_control_out,
   // request lines
   output reg overrun_request_out,
   output reg underrun_request_out,
   output reg rx_full_request_out,
   output reg tx_empty_request_out,
   output reg dma_rx_request_out,
   output reg dma_tx_request_out,
   output reg [1:0] top_request_code_out,
   output reg top_request_valid_out,
   output reg irq_out
);
   reg [15:0] ctrl_q;
   reg rx_full_flag_q;
   reg tx_empty_flag_q;
   reg overrun_flag_q;
   reg underrun_flag_q;
   // per-flag armed bit: set when software reads the flag as 1
   reg [3:0] read_armed_q;
   reg [3:0] irq_stat_q;
   reg [3:0] irq_mask_q;
   reg [3:0] aw_addr_q;
   reg aw_have_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_have_q;
   wire [3:0] flags;
   wire do_write;
   wire wr_ok;
   wire wr_ctrl;
   wire wr_stat;
   wire wr_istat;
   wire wr_imask;
   wire [3:0] sw_clear;
   wire tx_en_fall;
   wire rx_en_fall;
   wire [15:0] ctrl_new;
   wire do_read;
   wire rd_stat;
   wire [3:0] events;
   wire rx_en;
   wire tx_en;
   wire rx_ie;
   wire tx_ie;
   wire rx_full_set;
   wire tx_empty_set;
   wire overrun_flag_d_set;
   wire underrun_flag_d_set;
   reg [31:0] rd_data;
   reg rd_ok;

   assign flags = {underrun_flag_q, overrun_flag_q, tx_empty_flag_q, rx_full_flag_q};
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid_out;
   assign wr_ok = do_write && (aw_addr_q[1:0] == 2'b00);
   assign wr_ctrl = wr_ok && (aw_addr_q == `SPS_ADDR_CTRL) && w_strb_q[0];
   assign wr_stat = wr_ok && (aw_addr_q == `SPS_ADDR_STAT) && w_strb_q[0];
   assign wr_istat = wr_ok && (aw_addr_q == `SPS_ADDR_IRQ_STAT) && w_strb_q[0];
   assign wr_imask = wr_ok && (aw_addr_q == `SPS_ADDR_IRQ_MASK) && w_strb_q[0];
   // clear only a flag written 0 after it was read as 1
   assign sw_clear = {4{wr_stat}} & ~w_data_q[3:0] & read_armed_q;
   assign ctrl_new = wr_ctrl ? (w_data_q[15:0] & `SPS_CTRL_WMASK) : ctrl_q;
   assign tx_en_fall = ctrl_q[`SPS_CTRL_TX_EN] && !ctrl_new[`SPS_CTRL_TX_EN];
   assign rx_en_fall = ctrl_q[`SPS_CTRL_RX_EN] && !ctrl_new[`SPS_CTRL_RX_EN];
   assign rx_en = ctrl_q[`SPS_CTRL_RX_EN];
   assign tx_en = ctrl_q[`SPS_CTRL_TX_EN];
   assign rx_ie = ctrl_q[`SPS_CTRL_RX_IE];
   assign tx_ie = ctrl_q[`SPS_CTRL_TX_IE];
   assign do_read = s_axi_arvalid_in && s_axi_arready_out;
   assign rd_stat = do_read && (s_axi_araddr_in == `SPS_ADDR_STAT);
   // set conditions of the flags feed the sticky interrupt status
   assign events = {underrun_flag_d_set, overrun_flag_d_set, tx_empty_set, rx_full_set};

   assign rx_full_set = rx_done_in && rx_en && !rx_full_flag_q;
   assign overrun_flag_d_set = rx_done_in && rx_en && rx_full_flag_q;
   assign tx_empty_set = (tx_load_shift_in && tx_en) || tx_en_fall;
   assign underrun_flag_d_set = tx_start_in && tx_en && tx_empty_flag_q;

   always @*
   begin
      rd_data = 32'h0000_0000;
      rd_ok = 1'b1;
      case (s_axi_araddr_in)
         `SPS_ADDR_CTRL: rd_data = {16'h0000, ctrl_q};
         `SPS_ADDR_STAT: rd_data = {28'h000_0000, flags};
         `SPS_ADDR_IRQ_STAT: rd_data = {28'h000_0000, irq_stat_q};
         `SPS_ADDR_IRQ_MASK: rd_data = {28'h000_0000, irq_mask_q};
         default: rd_ok = 1'b0;
      endcase
   end

   // write address channel: one-cycle ready pulse, address held until the write is done
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         s_axi_awready_out <= 1'b0;
         aw_addr_q <= 4'h0;
         aw_have_q <= 1'b0;
      end
      else
      begin
         s_axi_awready_out <= !aw_have_q && !s_axi_awready_out && s_axi_awvalid_in;
         if (s_axi_awvalid_in && s_axi_awready_out)
         begin
            aw_addr_q <= s_axi_awaddr_in;
            aw_have_q <= 1'b1;
         end
         else if (do_write)
            aw_have_q <= 1'b0;
      end
   end

   // write data channel: taken independently of the address
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         s_axi_wready_out <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         w_have_q <= 1'b0;
      end
      else
      begin
         s_axi_wready_out <= !w_have_q && !s_axi_wready_out && s_axi_wvalid_in;
         if (s_axi_wvalid_in && s_axi_wready_out)
         begin
            w_data_q <= s_axi_wdata_in;
            w_strb_q <= s_axi_wstrb_in;
            w_have_q <= 1'b1;
         end
         else if (do_write)
            w_have_q <= 1'b0;
      end
   end

   // write response once both halves are held
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `SPS_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid_out <= 1'b1;
         if (wr_ok && (aw_addr_q <= `SPS_ADDR_IRQ_MASK))
            s_axi_bresp_out <= `SPS_RESP_OKAY;
         else
            s_axi_bresp_out <= `SPS_RESP_SLVERR;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
         s_axi_bvalid_out <= 1'b0;
   end

   // read address channel: no new address while read data waits
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
         s_axi_arready_out <= 1'b0;
      else
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out && s_axi_arvalid_in;
   end

   // read data channel: data captured at the address handshake
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `SPS_RESP_OKAY;
      end
      else if (do_read)
      begin
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= rd_data;
         if (rd_ok)
            s_axi_rresp_out <= `SPS_RESP_OKAY;
         else
            s_axi_rresp_out <= `SPS_RESP_SLVERR;
      end
      else if (s_axi_rvalid_out && s_axi_rready_in)
         s_axi_rvalid_out <= 1'b0;
   end

   // control, flags, sticky status
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         ctrl_q <= `SPS_CTRL_RESET;
         rx_full_flag_q <= 1'b0;
         tx_empty_flag_q <= 1'b1;
         overrun_flag_q <= 1'b0;
         underrun_flag_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_new;
         // receive-full: set wins over clears in the same cycle
         if (rx_full_set)
            rx_full_flag_q <= 1'b1;
         else if (dma_rx_read_in || sw_clear[`SPS_STAT_RX_FULL] || rx_en_fall)
            rx_full_flag_q <= 1'b0;
         if (tx_empty_set)
            tx_empty_flag_q <= 1'b1;
         else if (dma_tx_write_in || sw_clear[`SPS_STAT_TX_EMPTY])
            tx_empty_flag_q <= 1'b0;
         if (overrun_flag_d_set)
            overrun_flag_q <= 1'b1;
         else if (sw_clear[`SPS_STAT_OVERRUN])
            overrun_flag_q <= 1'b0;
         if (underrun_flag_d_set)
            underrun_flag_q <= 1'b1;
         else if (sw_clear[`SPS_STAT_UNDERRUN])
            underrun_flag_q <= 1'b0;
      end
   end

   // arming: a read that sees a 1 arms, a status write with strobe bit 0 set disarms
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
         read_armed_q <= 4'h0;
      else if (rd_stat)
         read_armed_q <= flags;
      else if (wr_stat)
         read_armed_q <= 4'h0;
   end

   // sticky interrupt status, write one to clear; a new event wins over the clear
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         irq_stat_q <= 4'h0;
         irq_mask_q <= 4'h0;
      end
      else
      begin
         irq_stat_q <= events | (irq_stat_q & ~({4{wr_istat}} & w_data_q[3:0]));
         if (wr_imask)
            irq_mask_q <= w_data_q[3:0];
      end
   end

   // interrupt level from unmasked sticky bits
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(irq_stat_q & irq_mask_q);
   end

   // request levels and priority encode
   always @(posedge ref_clk_in)
   begin
      if (!rstn_in)
      begin
         serial_control_out <= 7'h00;
         overrun_request_out <= 1'b0;
         underrun_request_out <= 1'b0;
         rx_full_request_out <= 1'b0;
         tx_empty_request_out <= 1'b0;
         dma_rx_request_out <= 1'b0;
         dma_tx_request_out <= 1'b0;
         top_request_code_out <= 2'b00;
         top_request_valid_out <= 1'b0;
      end
      else
      begin
         serial_control_out <= ctrl_q[6:0];
         overrun_request_out <= overrun_flag_q;
         underrun_request_out <= underrun_flag_q;
         rx_full_request_out <= rx_full_flag_q && rx_ie;
         tx_empty_request_out <= tx_empty_flag_q && tx_ie;
         dma_rx_request_out <= rx_full_flag_q && rx_ie;
         dma_tx_request_out <= tx_empty_flag_q && tx_ie;
         top_request_valid_out <= overrun_flag_q || underrun_flag_q ||
            (rx_full_flag_q && rx_ie) || (tx_empty_flag_q && tx_ie);
         if (overrun_flag_q)
            top_request_code_out <= 2'd0;
         else if (underrun_flag_q)
            top_request_code_out <= 2'd1;
         else if (rx_full_flag_q && rx_ie)
            top_request_code_out <= 2'd2;
         else
            top_request_code_out <= 2'd3;
      end
   end
endmodule // sps_status_irq
`default_nettype wire

// file: test/sps_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
module sps_dma_model
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // request side
   input wire logic en_in,
   input wire logic req_in,
   input wire logic [1:0] lat_in,
   // transfer strobe
   output logic strobe_out
);
   logic [2:0] wait_q;
   initial strobe_out = 1'b0;
   // serve after 0..3 idle cycles, then hold off until the request settles
   always @(posedge clk_in)
   begin
      strobe_out <= 1'b0;
      if (!rstn_in || !en_in)
         wait_q <= 3'h0;
      else if (wait_q != 3'h0)
      begin
         wait_q <= wait_q - 3'h1;
         strobe_out <= (wait_q == 3'h4);
      end
      else if (req_in)
         wait_q <= {1'b1, lat_in};
   end
endmodule // sps_dma_model
`default_nettype wire

// file: test/sps_status_irq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sps_status_irq_chk
(
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // engine and dma strobes
   input wire logic rx_done_in,
   input wire logic tx_start_in,
   input wire logic tx_load_shift_in,
   input wire logic dma_tx_write_in,
   input wire logic dma_rx_read_in,
   // outputs watched
   input wire logic s_axi_bvalid_out,
   input wire logic [6:0] serial_control_out,
   input wire logic overrun_request_out,
   input wire logic underrun_request_out,
   input wire logic rx_full_request_out,
   input wire logic tx_empty_request_out,
   input wire logic dma_rx_request_out,
   input wire logic dma_tx_request_out,
   input wire logic [1:0] top_request_code_out,
   input wire logic top_request_valid_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   a_dma_no_err: assert property (
      dma_rx_request_out == rx_full_request_out && dma_tx_request_out == tx_empty_request_out)
      else $error("dma request differs from data request");
   a_top_overrun: assert property (
      overrun_request_out |-> top_request_valid_out && top_request_code_out == 2'h0)
      else $error("overrun not on top");
   a_top_underrun: assert property (
      !overrun_request_out && underrun_request_out |-> top_request_code_out == 2'h1)
      else $error("underrun not on top");
   a_top_none: assert property (
      !(overrun_request_out | underrun_request_out | rx_full_request_out
      | tx_empty_request_out) |-> !top_request_valid_out)
      else $error("top valid with no source");
   a_overrun_set: assert property (
      rx_done_in && rx_full_request_out && serial_control_out[0] && !dma_rx_read_in
      && !$past(dma_rx_read_in) |-> ##[1:3] overrun_request_out)
      else $error("overrun missing");
   a_underrun_set: assert property (
      tx_start_in && tx_empty_request_out && serial_control_out[1] && !dma_tx_write_in
      && !$past(dma_tx_write_in) |-> ##[1:3] underrun_request_out)
      else $error("underrun missing");
   a_tx_dma_clear: assert property (
      dma_tx_write_in && !tx_load_shift_in && serial_control_out[1] |-> ##2 !tx_empty_request_out)
      else $error("tx empty kept after dma write");
   a_rx_dma_clear: assert property (
      dma_rx_read_in && !rx_done_in |-> ##2 !rx_full_request_out)
      else $error("rx full kept after dma read");
   a_err_hold: assert property (
      $fell(overrun_request_out) |-> $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2))
      else $error("overrun dropped without write");
   a_rx_gate: assert property (
      !serial_control_out[2] [*3] |-> !rx_full_request_out)
      else $error("rx full request while disabled");
   c_overrun: cover property (overrun_request_out);
   c_underrun: cover property (underrun_request_out);
   c_dma_write: cover property (dma_tx_write_in);
endmodule // sps_status_irq_chk
bind sps_status_irq sps_status_irq_chk u_chk (.ref_clk_in, .rstn_in, .rx_done_in, .tx_start_in,
   .tx_load_shift_in, .dma_tx_write_in, .dma_rx_read_in, .s_axi_bvalid_out, .serial_control_out,
   .overrun_request_out, .underrun_request_out, .rx_full_request_out, .tx_empty_request_out,
   .dma_rx_request_out, .dma_tx_request_out, .top_request_code_out, .top_request_valid_out);
`default_nettype wire

// file: test/sps_status_irq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.vh"
module sps_status_irq_tb_top;
   logic ref_clk_in, rstn_in, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
   logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
   logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, dma_on, irq_out;
   logic [3:0] s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
   logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, top_request_code_out, lat;
   logic tx_load_shift_in, tx_start_in, rx_done_in, dma_tx_write_in, dma_rx_read_in;
   logic overrun_request_out, underrun_request_out, rx_full_request_out, tx_empty_request_out;
   logic dma_rx_request_out, dma_tx_request_out, top_request_valid_out;
   logic [6:0] serial_control_out;
   logic [2:0] mode;
   logic [33:0] exp_q[$];
   integer miscompares = 0, check_count = 0, seed = 16480;
   sps_status_irq dut (.*);
   sps_dma_model u_rx_dma (.clk_in(ref_clk_in), .rstn_in(rstn_in), .en_in(dma_on),
      .req_in(dma_rx_request_out), .lat_in(lat), .strobe_out(dma_rx_read_in));
   sps_dma_model u_tx_dma (.clk_in(ref_clk_in), .rstn_in(rstn_in), .en_in(dma_on),
      .req_in(dma_tx_request_out), .lat_in(lat), .strobe_out(dma_tx_write_in));
   task close_out;
   begin
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   task chk(input string nm, input [33:0] e, input [33:0] s);
   begin
      check_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   end
   endtask
   task hang;
   begin
      miscompares++;
      close_out;
   end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      integer n;
   begin
      @(posedge ref_clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {16'h0000, d};
      {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
      for (n = 0; n < 40; n++)
      begin
         @(posedge ref_clk_in);
         if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
         if (s_axi_bvalid_out === 1'b1) break;
      end
      s_axi_bready_in <= 1'b0;
      if (n == 40) hang;
   end
   endtask
   task rd(input [3:0] a, input [15:0] d, input [1:0] r = 2'h0);
      integer n;
   begin
      exp_q.push_back({r, 16'h0000, d});
      @(posedge ref_clk_in);
      s_axi_araddr_in <= a;
      {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
      for (n = 0; n < 40; n++)
      begin
         @(posedge ref_clk_in);
         if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
         if (s_axi_rvalid_out === 1'b1) break;
      end
      s_axi_rready_in <= 1'b0;
      if (n == 40) hang;
   end
   endtask
   task ev(input [2:0] v);
   begin
      @(posedge ref_clk_in);
      {tx_load_shift_in, tx_start_in, rx_done_in} <= v;
      @(posedge ref_clk_in);
      {tx_load_shift_in, tx_start_in, rx_done_in} <= 3'h0;
      repeat (4) @(posedge ref_clk_in);
   end
   endtask
   initial
   begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in)
   begin
      lat <= 2'($random(seed));
      if (s_axi_rvalid_out === 1'b1 && s_axi_rready_in === 1'b1)
         chk("read", exp_q.pop_front(), {s_axi_rresp_out, s_axi_rdata_out});
   end
   initial
   begin
      {rstn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, dma_on} = 5'h00;
      {s_axi_arvalid_in, s_axi_rready_in, tx_load_shift_in, tx_start_in, rx_done_in} = 5'h00;
      {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, lat} = 42'h0;
      s_axi_wstrb_in = 4'hF;
      repeat (8) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      rd(`SPS_ADDR_CTRL, 16'h0000);
      rd(`SPS_ADDR_STAT, 16'h0002);
      mode = 3'($random(seed));
      wr(`SPS_ADDR_CTRL, {9'h000, mode, 4'hF});
      rd(`SPS_ADDR_CTRL, {9'h000, mode, 4'hF});
      ev(3'h1);
      rd(`SPS_ADDR_STAT, 16'h0003);
      chk("top", 2'h2, top_request_code_out);
      chk("txreq", 1'b1, tx_empty_request_out);
      ev(3'h1);
      rd(`SPS_ADDR_STAT, 16'h0007);
      chk("ovr", 1'b1, overrun_request_out);
      wr(`SPS_ADDR_STAT, 16'h0003);
      rd(`SPS_ADDR_STAT, 16'h0003);
      wr(`SPS_ADDR_STAT, 16'h0000);
      rd(`SPS_ADDR_STAT, 16'h0000);
      ev(3'h2);
      rd(`SPS_ADDR_STAT, 16'h0000);
      ev(3'h4);
      rd(`SPS_ADDR_STAT, 16'h0002);
      ev(3'h2);
      rd(`SPS_ADDR_STAT, 16'h000A);
      wr(`SPS_ADDR_STAT, 16'h0002);
      wr(`SPS_ADDR_STAT, 16'h0000);
      rd(`SPS_ADDR_STAT, 16'h0002);
      rd(4'h2, 16'h0000, `SPS_RESP_SLVERR);
      rd(`SPS_ADDR_IRQ_STAT, 16'h000F);
      wr(`SPS_ADDR_IRQ_MASK, 16'h0001);
      wr(`SPS_ADDR_IRQ_STAT, 16'h000F);
      rd(`SPS_ADDR_IRQ_STAT, 16'h0000);
      chk("irq", 1'b0, irq_out);
      ev(3'h1);
      chk("irq", 1'b1, irq_out);
      wr(`SPS_ADDR_CTRL, 16'h0003);
      repeat (4) @(posedge ref_clk_in);
      chk("gate", 2'h0, {rx_full_request_out, tx_empty_request_out});
      wr(`SPS_ADDR_CTRL, 16'h000F);
      dma_on <= 1'b1;
      repeat (12) @(posedge ref_clk_in);
      rd(`SPS_ADDR_STAT, 16'h0000);
      ev(3'h5);
      repeat (12) @(posedge ref_clk_in);
      rd(`SPS_ADDR_STAT, 16'h0000);
      dma_on <= 1'b0;
      wr(`SPS_ADDR_CTRL, 16'h000D);
      rd(`SPS_ADDR_STAT, 16'h0002);
      ev(3'h1);
      wr(`SPS_ADDR_CTRL, 16'h000C);
      rd(`SPS_ADDR_STAT, 16'h0002);
      repeat (4) @(posedge ref_clk_in);
      close_out;
   end
endmodule // sps_status_irq_tb_top
`default_nettype wire
